//--- verilog/cepc_pkg.sv
// Constants shared by the channel enable and power configuration block.
package cepc_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam int unsigned CEPC_ADDR_W = 8;
	localparam int unsigned CEPC_DATA_W = 8;
	localparam logic [7:0] CEPC_ADDR_IN_EN = 8'h73;
	localparam logic [7:0] CEPC_ADDR_OUT_EN = 8'h74;
	localparam logic [7:0] CEPC_ADDR_POWER_CONFIGURATION = 8'h75;
	localparam logic [7:0] CEPC_ADDR_PWR_STS = 8'h76;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] CEPC_RST_IN_EN = 8'hF0;
	localparam logic [7:0] CEPC_RST_OUT_EN = 8'h00;
	localparam logic [7:0] CEPC_RST_POWER_CONFIGURATION = 8'h00;

	// ------------------------------------------------------------
	// Power configuration fields
	// ------------------------------------------------------------
	localparam int unsigned CEPC_MIC_BIAS_BIT = 7;
	localparam int unsigned CEPC_CONV_BIT = 6;
	localparam int unsigned CEPC_SYNTH_BIT = 5;
	localparam int unsigned CEPC_DYN_BIT = 4;
	localparam int unsigned CEPC_RANGE_HI = 3;
	localparam int unsigned CEPC_RANGE_LO = 2;
	localparam logic [7:0] CEPC_POWER_CONFIGURATION_WMASK = 8'hFC;

	// Channel masks per range select value; bit 7 is channel 1.
	localparam logic [7:0] CEPC_RANGE_CH2 = 8'hC0;
	localparam logic [7:0] CEPC_RANGE_CH4 = 8'hF0;
	localparam logic [7:0] CEPC_RANGE_CH6 = 8'hFC;
	localparam logic [7:0] CEPC_RANGE_CH8 = 8'hFF;

	// Channels 5 to 8 accept digital microphone sources only.
	localparam logic [7:0] CEPC_PDM_ONLY_MASK = 8'h0F;

endpackage

//--- verilog/cepc_chan_pwr.sv
// Power state of one converter channel.
`timescale 1ns/1ps
`default_nettype none
module cepc_chan_pwr (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic conv_on_i,
	input wire logic dyn_mode_i,
	input wire logic in_range_i,
	input wire logic enable_i,
	input wire logic recording_i,
	output logic powered_o
);
	logic powered_q;
	logic powered_d;
	logic may_change;

	// Outside dynamic mode a running recording freezes every channel, so
	// an enable change only lands once all channels have gone quiet.
	assign may_change = (dyn_mode_i && in_range_i) || !recording_i;
	assign powered_d = !conv_on_i ? 1'b0 :
		(may_change ? enable_i : powered_q);
	assign powered_o = powered_q;

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			powered_q <= 1'b0;
		end else begin
			powered_q <= powered_d;
		end
	end

	property p_off_when_conv_off;
		@(posedge sys_clk_i) disable iff (srst_i)
			!conv_on_i |=> !powered_o;
	endproperty
	a_off_when_conv_off: assert property (p_off_when_conv_off)
		else $error("Channel stayed powered with converter off.");

	property p_frozen;
		@(posedge sys_clk_i) disable iff (srst_i)
			conv_on_i && !dyn_mode_i && recording_i |=> $stable(powered_o);
	endproperty
	a_frozen: assert property (p_frozen)
		else $error("Channel power changed during recording.");

	property p_dynamic;
		@(posedge sys_clk_i) disable iff (srst_i)
			conv_on_i && dyn_mode_i && in_range_i |=>
			powered_o == $past(enable_i);
	endproperty
	a_dynamic: assert property (p_dynamic)
		else $error("Dynamic channel did not follow its enable.");

endmodule
`default_nettype wire

//--- verilog/cepc_top.sv
// Channel enable, output slot enable and power configuration registers.
`timescale 1ns/1ps
`default_nettype none
module cepc_top (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [cepc_pkg::CEPC_ADDR_W-1:0] reg_addr_i,
	input wire logic [cepc_pkg::CEPC_DATA_W-1:0] reg_wdata_i,
	output logic [cepc_pkg::CEPC_DATA_W-1:0] reg_rdata_o,
	input wire logic [2:0] slot_index_i,
	input wire logic slot_data_i,
	output logic sdout_o,
	output logic sdout_oe_o,
	output logic mic_bias_power_up_o,
	output logic converter_power_up_o,
	output logic freq_synth_power_up_o,
	output logic [7:0] channel_power_o
);
	import cepc_pkg::*;

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [7:0] in_en_q;
	logic [7:0] out_en_q;
	logic [7:0] power_configuration_q;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic sdout_q;
	logic sdout_oe_q;
	logic [7:0] ch_pwr;
	logic [7:0] range_mask;
	logic [1:0] range_sel;
	logic wr_in_en;
	logic wr_out_en;
	logic wr_power_configuration;
	logic recording;
	logic slot_on;

	assign wr_in_en = reg_wr_i && (reg_addr_i == CEPC_ADDR_IN_EN);
	assign wr_out_en = reg_wr_i && (reg_addr_i == CEPC_ADDR_OUT_EN);
	assign wr_power_configuration = reg_wr_i && (reg_addr_i == CEPC_ADDR_POWER_CONFIGURATION);

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			in_en_q <= CEPC_RST_IN_EN;
			out_en_q <= CEPC_RST_OUT_EN;
			power_configuration_q <= CEPC_RST_POWER_CONFIGURATION;
		end else begin
			if (wr_in_en) begin
				in_en_q <= reg_wdata_i;
			end
			if (wr_out_en) begin
				out_en_q <= reg_wdata_i;
			end
			if (wr_power_configuration) begin
				power_configuration_q <= reg_wdata_i & CEPC_POWER_CONFIGURATION_WMASK;
			end
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	// Unmapped addresses read as zero so a stray read is harmless.
	assign rdata_d = !reg_rd_i ? rdata_q :
		(reg_addr_i == CEPC_ADDR_IN_EN) ? in_en_q :
		(reg_addr_i == CEPC_ADDR_OUT_EN) ? out_en_q :
		(reg_addr_i == CEPC_ADDR_POWER_CONFIGURATION) ? power_configuration_q :
		(reg_addr_i == CEPC_ADDR_PWR_STS) ? ch_pwr : 8'h00;

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end
	assign reg_rdata_o = rdata_q;

	// ------------------------------------------------------------
	// Power control
	// ------------------------------------------------------------
	assign mic_bias_power_up_o = power_configuration_q[CEPC_MIC_BIAS_BIT];
	assign converter_power_up_o = power_configuration_q[CEPC_CONV_BIT];
	assign freq_synth_power_up_o = power_configuration_q[CEPC_SYNTH_BIT];
	assign range_sel = power_configuration_q[CEPC_RANGE_HI:CEPC_RANGE_LO];
	assign range_mask = (range_sel == 2'h0) ? CEPC_RANGE_CH2 :
		(range_sel == 2'h1) ? CEPC_RANGE_CH4 :
		(range_sel == 2'h2) ? CEPC_RANGE_CH6 : CEPC_RANGE_CH8;
	assign recording = |ch_pwr;

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_chan
			cepc_chan_pwr u_chan (
				.sys_clk_i(sys_clk_i),
				.srst_i(srst_i),
				.conv_on_i(power_configuration_q[CEPC_CONV_BIT]),
				.dyn_mode_i(power_configuration_q[CEPC_DYN_BIT]),
				.in_range_i(range_mask[gi]),
				.enable_i(in_en_q[gi]),
				.recording_i(recording),
				.powered_o(ch_pwr[gi])
			);
		end
	endgenerate
	assign channel_power_o = ch_pwr;

	// ------------------------------------------------------------
	// Serial output slot drive
	// ------------------------------------------------------------
	// Slot 0 carries channel 1, which sits in bit 7 of the enables.
	assign slot_on = out_en_q[3'd7 - slot_index_i];

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			sdout_q <= 1'b0;
			sdout_oe_q <= 1'b0;
		end else begin
			sdout_q <= slot_on ? slot_data_i : 1'b0;
			sdout_oe_q <= slot_on;
		end
	end
	assign sdout_o = sdout_q;
	assign sdout_oe_o = sdout_oe_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_in_en_reset;
		@(posedge sys_clk_i) srst_i |=> in_en_q == CEPC_RST_IN_EN;
	endproperty
	a_in_en_reset: assert property (p_in_en_reset)
		else $error("Input enables not at reset value.");

	property p_slot_drive;
		@(posedge sys_clk_i) disable iff (srst_i)
			1'b1 |=> sdout_oe_o == $past(out_en_q[3'd7 - slot_index_i]);
	endproperty
	a_slot_drive: assert property (p_slot_drive)
		else $error("Slot drive does not match its enable.");

	property p_slots_reset;
		@(posedge sys_clk_i)
			srst_i ##1 !srst_i |-> !sdout_oe_o && out_en_q == 8'h00;
	endproperty
	a_slots_reset: assert property (p_slots_reset)
		else $error("Output slot driven after reset.");

	property p_bias;
		@(posedge sys_clk_i) disable iff (srst_i)
			wr_power_configuration |=>
			mic_bias_power_up_o == $past(reg_wdata_i[CEPC_MIC_BIAS_BIT])
			&& freq_synth_power_up_o == $past(reg_wdata_i[CEPC_SYNTH_BIT]);
	endproperty
	a_bias: assert property (p_bias)
		else $error("Bias or synthesizer control missed a write.");

	property p_only_enabled;
		@(posedge sys_clk_i) disable iff (srst_i)
			converter_power_up_o && !recording |=> ch_pwr == $past(in_en_q);
	endproperty
	a_only_enabled: assert property (p_only_enabled)
		else $error("Powered channels differ from enables.");

	// Each step of the select adds two channels below channel 1.
	property p_range;
		@(posedge sys_clk_i) disable iff (srst_i)
			range_mask == ~(8'h3F >> {range_sel, 1'b0});
	endproperty
	a_range: assert property (p_range)
		else $error("Range mask does not match the selected range.");

	property p_low_zero;
		@(posedge sys_clk_i) disable iff (srst_i)
			power_configuration_q[1:0] == 2'h0;
	endproperty
	a_low_zero: assert property (p_low_zero)
		else $error("Reserved power bits not zero.");

	property p_status_read;
		@(posedge sys_clk_i) disable iff (srst_i)
			reg_rd_i && reg_addr_i == CEPC_ADDR_PWR_STS |=>
			reg_rdata_o == $past(ch_pwr);
	endproperty
	a_status_read: assert property (p_status_read)
		else $error("Status read does not show channel power.");

	// A converter clear or a switch to dynamic mode right after the write
	// may legally move the channels, so the hold is only owed without one.
	property p_defer;
		@(posedge sys_clk_i) disable iff (srst_i)
			converter_power_up_o && !power_configuration_q[CEPC_DYN_BIT] && recording
			&& wr_in_en |=> (converter_power_up_o
			&& !power_configuration_q[CEPC_DYN_BIT] |=> $stable(ch_pwr));
	endproperty
	a_defer: assert property (p_defer)
		else $error("Enable change applied during recording.");

	c_power_up: cover property (@(posedge sys_clk_i) disable iff (srst_i)
		!recording ##1 recording);
	c_dynamic: cover property (@(posedge sys_clk_i) disable iff (srst_i)
		power_configuration_q[CEPC_DYN_BIT] && recording && $changed(ch_pwr));
	c_slot: cover property (@(posedge sys_clk_i) disable iff (srst_i)
		sdout_oe_o && sdout_o);
	c_status: cover property (@(posedge sys_clk_i) disable iff (srst_i)
		reg_rd_i && reg_addr_i == CEPC_ADDR_PWR_STS && recording);

endmodule
`default_nettype wire

//--- tb/cepc_host.sv
// Host model that drives the register strobe port of the block.
`timescale 1ns/1ps
`default_nettype none
module cepc_host
	import cepc_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic [7:0] rdata_i,
	output logic wr_o,
	output logic rd_o,
	output logic [7:0] addr_o,
	output logic [7:0] wdata_o
);
	logic dyn_q;

	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = 8'h00;
		wdata_o = 8'h00;
		dyn_q = 1'b0;
	end

	// ------------------------------------------------------------
	// One access, launched and released on falling edges
	// ------------------------------------------------------------
	task automatic access(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q);
		if (w && a == CEPC_ADDR_POWER_CONFIGURATION) begin
			dyn_q = d[CEPC_DYN_BIT];
		end
		if (w && a == CEPC_ADDR_IN_EN && dyn_q) begin
			d[7] = 1'b1;
		end
		@(negedge sys_clk_i);
		addr_o = a;
		wdata_o = d;
		wr_o = w;
		rd_o = !w;
		@(negedge sys_clk_i);
		q = rdata_i;
		wr_o = 1'b0;
		rd_o = 1'b0;
		// Idle bus shows no stale value, so a late sample cannot pass.
		addr_o = ~a;
		wdata_o = ~d;
	endtask
endmodule
`default_nettype wire

//--- tb/tb_cepc_top.sv
// Self-checking testbench of the channel enable and power block.
`timescale 1ns/1ps
`default_nettype none
module tb_cepc_top;
	import cepc_pkg::*;
	logic sys_clk, srst, wr, rd, slot_data, sdout, sdout_oe;
	logic mic, conv, synth;
	logic [7:0] addr, wdata, rdata, chpwr, m;
	logic [2:0] slot_index;
	int failures, n_compared;

	cepc_top cepc_top_inst (.sys_clk_i(sys_clk), .srst_i(srst),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_rdata_o(rdata),
		.slot_index_i(slot_index), .slot_data_i(slot_data),
		.sdout_o(sdout), .sdout_oe_o(sdout_oe),
		.mic_bias_power_up_o(mic), .converter_power_up_o(conv),
		.freq_synth_power_up_o(synth), .channel_power_o(chpwr));
	cepc_host cepc_host_inst (.sys_clk_i(sys_clk), .rdata_i(rdata),
		.wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h, want %h", $time, got, exp);
		end
	endtask
	task automatic wrr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		cepc_host_inst.access(1'b1, a, d, q);
		repeat (2) @(negedge sys_clk);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] q;
		cepc_host_inst.access(1'b0, a, 8'h00, q);
		chk(q, exp);
	endtask
	task automatic slot(input int i, input logic d, input logic en);
		slot_index = i[2:0];
		slot_data = d;
		@(negedge sys_clk);
		chk({6'h00, sdout_oe, sdout}, {6'h00, en, en & d});
	endtask
	task automatic end_of_test;
		$display("compared %0d, mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		#200000;
		failures++;
		end_of_test();
	end

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		failures = 0;
		n_compared = 0;
		srst = 1'b1;
		slot_index = 3'd0;
		slot_data = 1'b0;
		repeat (10) @(negedge sys_clk);
		srst = 1'b0;
		rdc(8'h73, 8'hF0);
		rdc(8'h74, 8'h00);
		rdc(8'h75, 8'h00);
		rdc(8'h76, 8'h00);
		rdc(8'h00, 8'h00);
		chk({5'h00, mic, conv, synth} | chpwr, 8'h00);
		for (int i = 0; i < 8; i++) slot(i, 1'b1, 1'b0);
		$display("test reset done");
		wrr(8'h75, 8'hE3);
		rdc(8'h75, 8'hE0);
		chk({5'h00, mic, conv, synth}, 8'h07);
		chk(chpwr, 8'hF0);
		wrr(8'h76, 8'h55);
		rdc(8'h76, 8'hF0);
		wrr(8'h73, 8'hFF);
		chk(chpwr, 8'hF0);
		rdc(8'h73, 8'hFF);
		wrr(8'h75, 8'hA0);
		chk({5'h00, mic, conv, synth}, 8'h05);
		chk(chpwr, 8'h00);
		wrr(8'h75, 8'hE0);
		chk(chpwr, 8'hFF);
		$display("test static power done");
		for (int s = 0; s < 4; s++) begin
			m = 8'hFF << (6 - 2 * s);
			wrr(8'h75, 8'h00);
			wrr(8'h75, 8'hD0 | 8'(s << 2));
			chk(chpwr, 8'hFF);
			wrr(8'h73, 8'h80);
			chk(chpwr, 8'h80 | ~m);
			wrr(8'h73, 8'hFF);
			chk(chpwr, 8'hFF);
		end
		$display("test dynamic power done");
		m = 8'hA5;
		wrr(8'h74, m);
		rdc(8'h74, 8'hA5);
		for (int i = 0; i < 8; i++) slot(i, !i[0], m[7 - i]);
		$display("test output slots done");
		end_of_test();
	end
endmodule
`default_nettype wire
